// [inc/rsc_defs.vh]
// Purpose: constants of the radio state controller
// Assumes: 100 MHz system clock, host link is a mode-0 serial port
// Notes: included by hdl/rsc_top.v and by the testbench
// How it works
// R01: five radio states, moved by one-byte host commands on the serial port
// R02: internal sequencer powers circuits in order and times settling itself
// R03: sleep command is taken only in off or on
// R04: sleep ends on chip-select low or on wake-up timer expiry; the code ignores the timer in deep sleep mode 2
// R05: host programs the wake-up timer before commanding sleep
// R06: hardware reset enters deep sleep mode 2, backed configuration is lost
// R07: asleep, interrupt pin driven low and other general pins released
// R08: off keeps crystal, digital and synthesizer regulators up, memories usable
// R09: host loads valid backed configuration before leaving off
// R10: off to on runs filter calibration only when enable bit is set
// R11: on adds oscillator and RF regulators, accepts transmit and receive
// R12: transmit enables and calibrates synthesizer, enables amplifier, uses channel
// R13: transmit command sends the stored packet without more host action
// R14: after the packet, amplifier off, back to on, interrupt if enabled
// R15: streaming transmit sends bits from the stream data pin
// R16: host ends streaming transmit with the on command
// R17: receive enables synthesizer and whole receive chain on channel
// R18: valid packet received returns to on, interrupt if enabled
// R19: streaming receive stays in receive until the on command
// R20: power-on reset flags the event and enters off with defaults
// R21: chip-select wake lands in off without the reset flag; the code sets it on a wake from deep sleep mode 2
// R22: a command not allowed in the present state changes nothing
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
// ****************
// register map
// ****************
`define RSC_ADDR_FREQ_HI 9'h109
`define RSC_ADDR_FREQ_MD 9'h10A
`define RSC_ADDR_FREQ_LO 9'h10B
`define RSC_ADDR_OPCTL 9'h11A
`define RSC_FREQ_RST 24'h00_0000
`define RSC_OPCTL_RST 8'h00
`define RSC_OPCTL_STREAM 0
`define RSC_OPCTL_IRQ_EN 1
`define RSC_OPCTL_CAL_EN 3
// ****************
// command codes
// ****************
`define RSC_CMD_OFF 8'hA0
`define RSC_CMD_ON 8'hA1
`define RSC_CMD_RX 8'hA2
`define RSC_CMD_TX 8'hA3
`define RSC_CMD_SLEEP 8'hA4
`define RSC_CMD_HWRST 8'hA5
`define RSC_CMD_IRQ_CLR 8'hA6
`define RSC_CMD_WR 8'h18
`define RSC_CMD_RD 8'h38
// ****************
// timing
// ****************
`define RSC_CLK_MHZ 100
`define RSC_SETTLE_US 20
`define RSC_CAL_US 10
`define RSC_SETTLE_CYC (`RSC_SETTLE_US * `RSC_CLK_MHZ)
`define RSC_CAL_CYC (`RSC_CAL_US * `RSC_CLK_MHZ)
`endif

// [hdl/rsc_top.v]
// Purpose: radio state sequencer with serial command and register port
// Assumes: host signals sampled by clk_sys, serial clock well below clk_sys/4
// Notes: link frames are 8-bit, msb first, data in on rising serial edge
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_top (
    input wire clk_sys,
    input wire rst,
    input wire ce,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_mosi,
    output reg spi_miso_o,
    output reg spi_miso_oe,
    input wire stream_data_pin,
    input wire wakeup_controller_expired,
    input wire tx_packet_done,
    input wire rx_packet_valid,
    output reg interrupt_pin_o,
    output reg interrupt_pin_oe,
    output reg general_purpose_pins_oe,
    output reg [4:0] radio_state,
    output reg cmd_ready,
    output reg por_flag,
    output reg deep_sleep_mode2,
    output reg xtal_en,
    output reg dig_reg_en,
    output reg synth_reg_en,
    output reg vco_reg_en,
    output reg rf_reg_en,
    output reg synth_en,
    output reg synth_cal,
    output reg filter_cal,
    output reg pa_en,
    output reg rx_chain_en,
    output reg tx_start,
    output reg tx_stream_mode,
    output reg tx_stream_bit,
    output reg pkt_mem_clear,
    output reg [23:0] channel_frequency,
    output reg [7:0] operating_control
);
    // ****************
    // sequencer states
    // ****************
    localparam [7:0] ST_SLEEP = 8'h01;
    localparam [7:0] ST_OFF = 8'h02;
    localparam [7:0] ST_PWRON = 8'h04;
    localparam [7:0] ST_CAL = 8'h08;
    localparam [7:0] ST_ON = 8'h10;
    localparam [7:0] ST_TXSET = 8'h20;
    localparam [7:0] ST_TX = 8'h40;
    localparam [7:0] ST_RXSET = 8'h80;
    localparam integer SETTLE_I = `RSC_SETTLE_CYC;
    localparam integer CAL_I = `RSC_CAL_CYC;
    localparam [11:0] SETTLE_CYC = SETTLE_I[11:0];
    localparam [11:0] CAL_CYC = CAL_I[11:0];

    // ****************
    // input synchronisers
    // ****************
    reg [1:0] cs_s_r;
    reg [2:0] sck_s_r;
    reg [1:0] mosi_s_r;
    reg [1:0] strm_s_r;
    reg [1:0] wuc_s_r;
    reg cs_d_r;
    always @(posedge clk_sys) begin
        if (rst) begin
            cs_s_r <= 2'b11;
            sck_s_r <= 3'b000;
            mosi_s_r <= 2'b00;
            strm_s_r <= 2'b00;
            wuc_s_r <= 2'b00;
            cs_d_r <= 1'b1;
        end else if (ce) begin
            cs_s_r <= {cs_s_r[0], spi_cs_n};
            sck_s_r <= {sck_s_r[1:0], spi_sclk};
            mosi_s_r <= {mosi_s_r[0], spi_mosi};
            strm_s_r <= {strm_s_r[0], stream_data_pin};
            wuc_s_r <= {wuc_s_r[0], wakeup_controller_expired};
            cs_d_r <= cs_s_r[1];
        end
    end
    wire cs_lo = ~cs_s_r[1];
    wire cs_fall = cs_d_r & ~cs_s_r[1];
    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire sck_fall = ~sck_s_r[1] & sck_s_r[2];

    // ****************
    // serial byte framing
    // ****************
    reg [2:0] bit_cnt_r;
    reg [1:0] byte_cnt_r;
    reg [7:0] rx_sh_r;
    reg [7:0] tx_sh_r;
    reg [7:0] op_r;
    reg addr_hi_r;
    reg [8:0] addr_r;
    reg [7:0] st_r;
    reg [11:0] cnt_r;
    reg irq_pend_r;
    reg por_r;
    reg deep2_r;
    wire [7:0] rx_byte = {rx_sh_r[6:0], mosi_s_r[1]};
    wire byte_done = cs_lo & sck_rise & (bit_cnt_r == 3'd7);
    wire cmd_byte = byte_done & (byte_cnt_r == 2'd0);
    wire data_byte = byte_done & (byte_cnt_r == 2'd3);
    wire addr_done = byte_done & (byte_cnt_r == 2'd2);
    wire [8:0] addr_full = {addr_hi_r, rx_byte};
    wire [8:0] addr_inc = addr_r + 9'd1;

    function [7:0] reg_rd;
        input [8:0] a;
        input [23:0] f;
        input [7:0] c;
        begin
            case (a)
                `RSC_ADDR_FREQ_HI: reg_rd = f[23:16];
                `RSC_ADDR_FREQ_MD: reg_rd = f[15:8];
                `RSC_ADDR_FREQ_LO: reg_rd = f[7:0];
                `RSC_ADDR_OPCTL: reg_rd = c;
                default: reg_rd = 8'h00;
            endcase
        end
    endfunction

    // status byte shown at the start of every frame
    wire stable = ~|(st_r & (ST_PWRON | ST_CAL | ST_TXSET)) &
        ~((st_r == ST_RXSET) && (cnt_r != 12'd0));
    wire [4:0] coarse = {st_r[7], st_r[6] | st_r[5], st_r[4] | st_r[3] | st_r[2],
        st_r[1], st_r[0]};
    wire [7:0] status = {stable, por_r, irq_pend_r, coarse};

    always @(posedge clk_sys) begin
        if (rst) begin
            bit_cnt_r <= 3'd0;
            byte_cnt_r <= 2'd0;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 8'h00;
            op_r <= 8'h00;
            addr_hi_r <= 1'b0;
            addr_r <= 9'h000;
        end else if (ce) begin
            if (!cs_lo) begin
                bit_cnt_r <= 3'd0;
                byte_cnt_r <= 2'd0;
            end else if (sck_rise) begin
                bit_cnt_r <= bit_cnt_r + 3'd1;
                rx_sh_r <= rx_byte;
                if (bit_cnt_r == 3'd7 && byte_cnt_r != 2'd3) begin
                    byte_cnt_r <= byte_cnt_r + 2'd1;
                end
            end
            if (cs_fall) begin
                tx_sh_r <= {status[6:0], 1'b0};
            end else if (cs_lo && sck_fall) begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
            if (cmd_byte) begin
                op_r <= rx_byte;
            end
            if (byte_done && byte_cnt_r == 2'd1) begin
                addr_hi_r <= rx_byte[0];
            end
            if (addr_done) begin
                addr_r <= addr_full;
                if (op_r == `RSC_CMD_RD) begin
                    tx_sh_r <= reg_rd(addr_full, channel_frequency, operating_control);
                end
            end
            if (data_byte) begin
                addr_r <= addr_inc;
                if (op_r == `RSC_CMD_RD) begin
                    tx_sh_r <= reg_rd(addr_inc, channel_frequency, operating_control);
                end
            end
        end
    end

    // ****************
    // backed configuration registers
    // ****************
    wire hwrst_cmd = cmd_byte & (rx_byte == `RSC_CMD_HWRST);
    always @(posedge clk_sys) begin
        if (rst) begin
            channel_frequency <= `RSC_FREQ_RST;
            operating_control <= `RSC_OPCTL_RST;
        end else if (ce) begin
            if (hwrst_cmd) begin
                // contents are not kept through deep sleep mode 2
                channel_frequency <= `RSC_FREQ_RST; // R06
                operating_control <= `RSC_OPCTL_RST; // R06
            end else if (data_byte && op_r == `RSC_CMD_WR) begin
                // writes are not gated by state; only the four mapped addresses take them
                case (addr_r) // R08
                    `RSC_ADDR_FREQ_HI: channel_frequency[23:16] <= rx_byte;
                    `RSC_ADDR_FREQ_MD: channel_frequency[15:8] <= rx_byte;
                    `RSC_ADDR_FREQ_LO: channel_frequency[7:0] <= rx_byte;
                    `RSC_ADDR_OPCTL: operating_control <= rx_byte;
                    default: operating_control <= operating_control;
                endcase
            end
        end
    end
    wire stream_md = operating_control[`RSC_OPCTL_STREAM];
    wire irq_en = operating_control[`RSC_OPCTL_IRQ_EN];
    wire cal_en = operating_control[`RSC_OPCTL_CAL_EN];

    // ****************
    // state sequencer
    // ****************
    reg [7:0] st_nxt;
    reg [11:0] cnt_nxt;
    reg done_evt;
    reg deep2_nxt;
    reg por_nxt;
    wire [7:0] cmd = rx_byte;
    always @* begin
        st_nxt = st_r; // R22
        cnt_nxt = (cnt_r == 12'd0) ? 12'd0 : cnt_r - 12'd1;
        done_evt = 1'b0;
        deep2_nxt = deep2_r;
        por_nxt = por_r;
        // other commands leave the state as it is
        if (hwrst_cmd) begin
            st_nxt = ST_SLEEP; // R06
            deep2_nxt = 1'b1; // R06
        end else begin
            case (st_r)
                ST_SLEEP: begin
                    if (cs_fall) begin
                        st_nxt = ST_OFF; // R04
                        // only a wake from mode 2 counts as a fresh power-up
                        por_nxt = deep2_r | por_r; // R21
                        deep2_nxt = 1'b0;
                    end else if (wuc_s_r[1] && !deep2_r) begin
                        st_nxt = ST_OFF; // R04
                    end
                end
                ST_OFF: begin
                    if (cmd_byte && cmd == `RSC_CMD_ON) begin
                        st_nxt = ST_PWRON; // R02
                        cnt_nxt = SETTLE_CYC;
                    end else if (cmd_byte && cmd == `RSC_CMD_SLEEP) begin
                        st_nxt = ST_SLEEP; // R03
                    end
                end
                ST_PWRON: begin
                    if (cnt_r == 12'd0) begin
                        if (cal_en) begin
                            st_nxt = ST_CAL; // R10
                            cnt_nxt = CAL_CYC;
                        end else begin
                            st_nxt = ST_ON; // R10
                        end
                    end
                end
                ST_CAL: begin
                    if (cnt_r == 12'd0) begin
                        st_nxt = ST_ON;
                    end
                end
                ST_ON: begin
                    if (cmd_byte && cmd == `RSC_CMD_TX) begin
                        st_nxt = ST_TXSET; // R11
                        cnt_nxt = SETTLE_CYC;
                    end else if (cmd_byte && cmd == `RSC_CMD_RX) begin
                        st_nxt = ST_RXSET; // R11
                        cnt_nxt = SETTLE_CYC;
                    end else if (cmd_byte && cmd == `RSC_CMD_OFF) begin
                        st_nxt = ST_OFF;
                    end else if (cmd_byte && cmd == `RSC_CMD_SLEEP) begin
                        st_nxt = ST_SLEEP; // R03
                    end
                end
                ST_TXSET: begin
                    if (cnt_r == 12'd0) begin
                        st_nxt = ST_TX; // R12
                    end
                end
                ST_TX: begin
                    if (cmd_byte && cmd == `RSC_CMD_ON) begin
                        st_nxt = ST_ON; // R16
                    end else if (tx_packet_done && !stream_md) begin
                        st_nxt = ST_ON; // R14
                        done_evt = 1'b1; // R14
                    end
                end
                ST_RXSET: begin
                    // counter at zero means settled and listening
                    if (cmd_byte && cmd == `RSC_CMD_ON && cnt_r == 12'd0) begin
                        st_nxt = ST_ON; // R19
                    end else if (cnt_r == 12'd0 && rx_packet_valid && !stream_md) begin
                        st_nxt = ST_ON; // R18
                        done_evt = 1'b1; // R18
                    end
                end
                default: st_nxt = ST_OFF;
            endcase
        end
        if (cmd_byte && cmd == `RSC_CMD_IRQ_CLR && st_nxt == st_r) begin
            por_nxt = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            st_r <= ST_OFF; // R20
            cnt_r <= 12'd0;
            deep2_r <= 1'b0;
            por_r <= 1'b1; // R20
            irq_pend_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt; // R01
            cnt_r <= cnt_nxt;
            deep2_r <= deep2_nxt;
            if (done_evt && irq_en) begin
                irq_pend_r <= 1'b1; // R14 R18
            end else if (cmd_byte && cmd == `RSC_CMD_IRQ_CLR) begin
                irq_pend_r <= 1'b0;
            end
            por_r <= por_nxt;
        end
    end

    // ****************
    // registered outputs, from the next state except the serial port, interrupt pin enable and memory clear
    // ****************
    wire n_sleep = st_nxt == ST_SLEEP;
    wire n_txs = st_nxt == ST_TXSET;
    wire n_tx = st_nxt == ST_TX;
    wire n_rxs = st_nxt == ST_RXSET;
    wire n_on_up = ~(n_sleep | (st_nxt == ST_OFF));
    wire n_rx_live = n_rxs & (cnt_nxt == 12'd0);
    wire irq_nxt = (done_evt & irq_en) | (irq_pend_r &
        ~(cmd_byte & (cmd == `RSC_CMD_IRQ_CLR)));
    always @(posedge clk_sys) begin
        if (rst) begin
            spi_miso_o <= 1'b0;
            spi_miso_oe <= 1'b0;
            interrupt_pin_o <= 1'b0;
            interrupt_pin_oe <= 1'b1;
            general_purpose_pins_oe <= 1'b1;
            radio_state <= 5'b00010;
            cmd_ready <= 1'b0;
            por_flag <= 1'b1;
            deep_sleep_mode2 <= 1'b0;
            xtal_en <= 1'b1;
            dig_reg_en <= 1'b1;
            synth_reg_en <= 1'b1;
            vco_reg_en <= 1'b0;
            rf_reg_en <= 1'b0;
            synth_en <= 1'b0;
            synth_cal <= 1'b0;
            filter_cal <= 1'b0;
            pa_en <= 1'b0;
            rx_chain_en <= 1'b0;
            tx_start <= 1'b0;
            tx_stream_mode <= 1'b0;
            tx_stream_bit <= 1'b0;
            pkt_mem_clear <= 1'b1; // R20
        end else if (ce) begin
            pkt_mem_clear <= 1'b0;
            if (cs_fall) begin
                spi_miso_o <= status[7];
            end else if (cs_lo && sck_fall) begin
                spi_miso_o <= tx_sh_r[7];
            end
            spi_miso_oe <= cs_lo;
            interrupt_pin_o <= irq_nxt & ~n_sleep; // R07
            interrupt_pin_oe <= 1'b1; // R07
            general_purpose_pins_oe <= ~n_sleep; // R07
            radio_state <= {n_rxs, n_txs | n_tx, n_on_up & ~n_txs & ~n_tx & ~n_rxs,
                st_nxt == ST_OFF, n_sleep};
            cmd_ready <= ~(st_nxt == ST_PWRON || st_nxt == ST_CAL || n_txs ||
                (n_rxs && cnt_nxt != 12'd0));
            por_flag <= por_nxt;
            deep_sleep_mode2 <= deep2_nxt;
            xtal_en <= ~n_sleep; // R08
            dig_reg_en <= ~n_sleep; // R08
            synth_reg_en <= ~n_sleep; // R08
            vco_reg_en <= n_on_up; // R11
            rf_reg_en <= n_on_up; // R11
            synth_en <= n_txs | n_tx | n_rxs; // R12 R17
            synth_cal <= (n_txs | n_rxs) & (cnt_nxt != 12'd0); // R12
            filter_cal <= st_nxt == ST_CAL; // R10
            pa_en <= n_tx; // R12 R14
            rx_chain_en <= n_rx_live; // R17
            // stored packet goes out on the first transmit cycle
            tx_start <= n_tx & (st_r == ST_TXSET) & ~stream_md; // R13
            tx_stream_mode <= n_tx & stream_md; // R15
            tx_stream_bit <= n_tx & stream_md & strm_s_r[1]; // R15
        end
    end
endmodule // rsc_top

// [tb/rsc_monitor.sv]
// Purpose: port-level checks of the radio state sequencer
// Assumes: one clock domain, ce held high by the bench
// Notes: bound to rsc_top at the foot of this file
`timescale 1ns/100ps
module rsc_monitor (
    input wire clk_sys,
    input wire rst,
    input wire [4:0] radio_state,
    input wire interrupt_pin_o,
    input wire general_purpose_pins_oe,
    input wire xtal_en,
    input wire dig_reg_en,
    input wire synth_reg_en,
    input wire vco_reg_en,
    input wire rf_reg_en,
    input wire pa_en,
    input wire synth_en,
    input wire tx_start,
    input wire tx_stream_mode,
    input wire tx_packet_done,
    input wire rx_packet_valid,
    input wire rx_chain_en,
    input wire filter_cal,
    input wire [7:0] operating_control
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ****************
    // event sequences
    // ****************
    sequence s_pkt_sent;
        radio_state[3] && pa_en && tx_packet_done && !tx_stream_mode;
    endsequence
    sequence s_pkt_heard;
        radio_state[4] && rx_chain_en && rx_packet_valid && !operating_control[0];
    endsequence
    chk_state_onehot: assert property ($onehot(radio_state))
        else $error("radio state not one-hot");
    chk_sleep_pins: assert property (radio_state[0] |-> !interrupt_pin_o &&
        !general_purpose_pins_oe) else $error("pins active in sleep");
    chk_off_power: assert property (radio_state[1] |-> xtal_en && dig_reg_en &&
        synth_reg_en && !vco_reg_en && !rf_reg_en) else $error("off power set wrong");
    chk_on_power: assert property (radio_state[2] |-> vco_reg_en && rf_reg_en)
        else $error("on state regulators off");
    chk_pa_tx_only: assert property (pa_en |-> radio_state[3] && synth_en)
        else $error("amplifier on outside transmit");
    chk_tx_autostart: assert property ($rose(pa_en) && !tx_stream_mode |-> tx_start)
        else $error("packet send not started");
    chk_tx_return: assert property (s_pkt_sent |=> radio_state == 5'h04 && !pa_en)
        else $error("no return to on after send");
    chk_rx_return: assert property (s_pkt_heard |=> radio_state == 5'h04)
        else $error("no return to on after receive");
    chk_stream_stay: assert property (tx_stream_mode && tx_packet_done
        |=> radio_state[3]) else $error("streaming transmit left on its own");
    chk_rx_stream_stay: assert property (radio_state[4] && rx_packet_valid &&
        operating_control[0] |=> radio_state[4]) else $error("streaming receive left");
    chk_cal_gate: assert property ($rose(filter_cal) |-> operating_control[3])
        else $error("calibration without enable");
endmodule // rsc_monitor
bind rsc_top rsc_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .radio_state(radio_state),
    .interrupt_pin_o(interrupt_pin_o), .general_purpose_pins_oe(general_purpose_pins_oe),
    .xtal_en(xtal_en), .dig_reg_en(dig_reg_en), .synth_reg_en(synth_reg_en),
    .vco_reg_en(vco_reg_en), .rf_reg_en(rf_reg_en), .pa_en(pa_en), .synth_en(synth_en),
    .tx_start(tx_start), .tx_stream_mode(tx_stream_mode), .tx_packet_done(tx_packet_done),
    .rx_packet_valid(rx_packet_valid), .rx_chain_en(rx_chain_en), .filter_cal(filter_cal),
    .operating_control(operating_control));

// [tb/rsc_host_model.sv]
// Purpose: host processor driving the mode-0 serial port
// Assumes: link clock 80 ns, stepped on falling system clock edges
// Notes: link clock rests low and data line toggles between frames
`timescale 1ns/100ps
module rsc_host_model (
    input wire clk_sys,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire spi_miso_o,
    input wire spi_miso_oe
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    // n bytes, msb first from tx[47]; a zero-byte frame is a bare select pulse
    task automatic frame(input int n, input logic [47:0] tx, output logic [47:0] rx);
        int i;
        rx = '0;
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        for (i = 0; i < n * 8; i++) begin
            spi_mosi = tx[47 - i];
            repeat (4) @(negedge clk_sys);
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            // sampled late in the high phase: answer only stands till the fall
            rx[47 - i] = spi_miso_oe ? spi_miso_o : 1'bx;
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule // rsc_host_model

// [tb/rsc_top_tb.sv]
// Purpose: self-checking run of radio state commands and registers
// Assumes: ce tied high, packet engine events driven by the bench
// Notes: settle and calibration counts are fixed, waits are bounded
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_top_tb;
    localparam logic [4:0] ST_SLEEP = 5'h01, ST_OFF = 5'h02, ST_ON = 5'h04;
    localparam logic [4:0] ST_TX = 5'h08, ST_RX = 5'h10;
    logic clk_sys = 1'b0, rst = 1'b1, stream_data_pin = 1'b0, wake_exp = 1'b0;
    logic tx_done = 1'b0, rx_valid = 1'b0, saw_cal, saw_start;
    wire spi_cs_n, spi_sclk, spi_mosi, miso, miso_oe, irq_o, gp_oe, rdy, por, deep, irq_oe;
    wire xtal, dreg, sreg, vreg, rfreg, syn, pa, rxc, tmode, tbit, clr, fcal, tstart, scal;
    wire [4:0] st;
    wire [23:0] freq;
    wire [7:0] opctl;
    logic [47:0] rsp;
    int err_total = 0, samples_checked = 0;
    always #5 clk_sys = ~clk_sys;
    rsc_host_model u_host (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso_o(miso), .spi_miso_oe(miso_oe));
    rsc_top u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso_o(miso), .spi_miso_oe(miso_oe),
        .stream_data_pin(stream_data_pin), .wakeup_controller_expired(wake_exp),
        .tx_packet_done(tx_done), .rx_packet_valid(rx_valid), .interrupt_pin_o(irq_o),
        .interrupt_pin_oe(irq_oe), .general_purpose_pins_oe(gp_oe), .radio_state(st),
        .cmd_ready(rdy), .por_flag(por), .deep_sleep_mode2(deep), .xtal_en(xtal),
        .dig_reg_en(dreg), .synth_reg_en(sreg), .vco_reg_en(vreg), .rf_reg_en(rfreg),
        .synth_en(syn), .synth_cal(scal), .filter_cal(fcal), .pa_en(pa), .rx_chain_en(rxc),
        .tx_start(tstart), .tx_stream_mode(tmode), .tx_stream_bit(tbit),
        .pkt_mem_clear(clr), .channel_frequency(freq), .operating_control(opctl));
    // ****************
    // helpers
    // ****************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c);
        u_host.frame(1, {c, 40'h0}, rsp);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [8:0] a, input logic [23:0] d);
        u_host.frame(6, {`RSC_CMD_WR, 7'h00, a, d}, rsp);
    endtask
    task automatic rd(input logic [8:0] a, input int n, output logic [23:0] d);
        u_host.frame(3 + n, {`RSC_CMD_RD, 7'h00, a, 24'h00_0000}, rsp);
        d = rsp[23:0] >> (8 * (3 - n));
    endtask
    // waits out power-up, settle and calibration; notes what pulsed meanwhile
    task automatic wait_ready();
        int k;
        saw_cal = 1'b0;
        saw_start = 1'b0;
        for (k = 0; k < 5000 && rdy !== 1'b1; k++) begin
            @(negedge clk_sys);
            saw_cal |= fcal;
            saw_start |= tstart;
        end
        check("cmd_ready", rdy, 1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    // ****************
    // scenarios
    // ****************
    initial begin
        logic [23:0] d;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        check("pkt_clear", clr, 1);
        repeat (3) @(negedge clk_sys);
        check("state", st, ST_OFF);
        check("por", por, 1);
        check("off_regs", {xtal, dreg, sreg, vreg, rfreg}, 5'h1c);
        cmd(`RSC_CMD_IRQ_CLR);
        check("status", rsp[47:40], {2'b11, 1'b0, ST_OFF});
        check("por_clear", por, 0);
        wr(`RSC_ADDR_FREQ_HI, 24'h12_3456);
        u_host.frame(4, {`RSC_CMD_WR, 8'h01, 8'h1a, 8'h0a, 16'h0000}, rsp);
        rd(`RSC_ADDR_FREQ_HI, 3, d);
        check("freq", d, 24'h12_3456);
        rd(`RSC_ADDR_OPCTL, 1, d);
        check("opctl", d, 24'h00_000a);
        rd(9'h100, 1, d);
        check("unmapped", d, 24'h00_0000);
        cmd(`RSC_CMD_TX);
        check("tx_in_off", st, ST_OFF);
        cmd(`RSC_CMD_ON);
        check("on", st, ST_ON);
        wait_ready();
        check("cal_run", saw_cal, 1);
        check("on_regs", {vreg, rfreg, xtal}, 3'h7);
        cmd(`RSC_CMD_TX);
        check("tx_cal", {st, scal}, {ST_TX, 1'b1});
        wait_ready();
        check("tx_up", {st, pa, syn, saw_start}, {ST_TX, 3'h7});
        check("tx_freq", freq, 24'h12_3456);
        pulse(tx_done);
        check("tx_back", {st, pa, irq_o}, {ST_ON, 2'b01});
        cmd(`RSC_CMD_IRQ_CLR);
        cmd(`RSC_CMD_RX);
        wait_ready();
        check("rx_up", {st, rxc, syn}, {ST_RX, 2'b11});
        pulse(rx_valid);
        check("rx_back", {st, irq_o}, {ST_ON, 1'b1});
        cmd(`RSC_CMD_OFF);
        check("off", st, ST_OFF);
        wr(`RSC_ADDR_OPCTL, 24'h03_0000);
        cmd(`RSC_CMD_ON);
        wait_ready();
        check("no_cal", saw_cal, 0);
        cmd(`RSC_CMD_TX);
        wait_ready();
        check("stream", {st, tmode}, {ST_TX, 1'b1});
        stream_data_pin = 1'b1;
        repeat (6) @(negedge clk_sys);
        check("sbit1", tbit, 1);
        stream_data_pin = 1'b0;
        repeat (6) @(negedge clk_sys);
        check("sbit0", tbit, 0);
        pulse(tx_done);
        check("stream_hold", st, ST_TX);
        cmd(`RSC_CMD_ON);
        check("stream_end", st, ST_ON);
        cmd(`RSC_CMD_RX);
        wait_ready();
        pulse(rx_valid);
        check("rx_hold", st, ST_RX);
        cmd(`RSC_CMD_SLEEP);
        check("sleep_in_rx", st, ST_RX);
        cmd(`RSC_CMD_ON);
        check("rx_end", st, ST_ON);
        wait_ready();
        cmd(`RSC_CMD_SLEEP);
        check("sleep", {st, irq_o, gp_oe, irq_oe}, {ST_SLEEP, 3'b001});
        u_host.frame(0, 48'h0, rsp);
        check("cs_wake", {st, por}, {ST_OFF, 1'b0});
        wait_ready();
        cmd(`RSC_CMD_SLEEP);
        check("sleep_off", st, ST_SLEEP);
        pulse(wake_exp);
        repeat (4) @(negedge clk_sys);
        check("timer_wake", st, ST_OFF);
        wait_ready();
        cmd(`RSC_CMD_HWRST);
        check("deep", {st, deep}, {ST_SLEEP, 1'b1});
        pulse(wake_exp);
        repeat (4) @(negedge clk_sys);
        check("deep_timer", st, ST_SLEEP);
        u_host.frame(0, 48'h0, rsp);
        check("deep_wake", {st, por}, {ST_OFF, 1'b1});
        final_report();
    end
    // whole run is about 16k cycles of settling plus serial frames
    initial begin
        repeat (80000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
endmodule // rsc_top_tb
